// ===== hdl/spl_pkg.sv
// Purpose: constants and types for the sector protection lock block
// Assumes: 40 MHz aclk, AXI4-Lite register access, 32-bit data
// Notes: byte offsets, command codes, field positions and timings
package spl_pkg;

    // ------------------------------------------------------------
    // geometry and timing
    // ------------------------------------------------------------
    localparam int NUM_BLOCKS = 256;
    localparam int BLK_W = 8;
    localparam int PWD_W = 64;
    localparam int ASP_W = 3;
    localparam int CNT_W = 13;
    localparam int CLK_PERIOD_NS = 25;
    localparam int UNLOCK_TIME_NS = 100000;
    localparam int UNLOCK_TOL_NS = 20000;
    localparam int PROG_TIME_NS = 2000;
    localparam int ERASE_TIME_NS = 4000;
    localparam int UNLOCK_CYC = UNLOCK_TIME_NS / CLK_PERIOD_NS;
    localparam int PROG_CYC = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int ERASE_CYC = ERASE_TIME_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DATA_LO = 8'h04;
    localparam logic [7:0] OFS_DATA_HI = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_BLK_SEL = 8'h10;
    localparam logic [7:0] OFS_RDBK_LO = 8'h14;
    localparam logic [7:0] OFS_RDBK_HI = 8'h18;
    localparam logic [7:0] OFS_ASP = 8'h1C;

    // ------------------------------------------------------------
    // command word fields and codes
    // ------------------------------------------------------------
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_BLK_LSB = 8;
    localparam int CMD_VAL_BIT = 16;
    localparam int ASP_PERSIST_BIT = 1;
    localparam int ASP_PWD_BIT = 2;
    localparam logic [3:0] OP_PROG_GUARD = 4'h1;
    localparam logic [3:0] OP_ERASE_GUARD = 4'h2;
    localparam logic [3:0] OP_WRITE_VOL = 4'h3;
    localparam logic [3:0] OP_LOCK_CLEAR = 4'h4;
    localparam logic [3:0] OP_PWD_PROG = 4'h5;
    localparam logic [3:0] OP_PWD_READ = 4'h6;
    localparam logic [3:0] OP_PWD_UNLOCK = 4'h7;
    localparam logic [3:0] OP_ASP_PROG = 4'h8;
    localparam logic [3:0] OP_SOFT_RESET = 4'h9;
    localparam logic [3:0] OP_POWER_CYCLE = 4'hA;
    localparam logic [3:0] OP_CLR_ERR = 4'hB;

    // ------------------------------------------------------------
    // reset values and bus answers
    // ------------------------------------------------------------
    localparam logic [PWD_W-1:0] PWD_FACTORY = 64'hFFFFFFFFFFFFFFFF;
    localparam logic [ASP_W-1:0] ASP_FACTORY = 3'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_PROG = 4'h2,
        ST_ERASE = 4'h4,
        ST_WAIT = 4'h8
    } spl_state_e;

    typedef struct packed {
        logic read_blocked;
        logic persist_mode;
        logic pwd_mode;
        logic lock;
        logic prot_err;
        logic prog_err;
        logic pending;
    } spl_status_s;

endpackage

// ===== hdl/spl_top.sv
// Purpose: sector protection lock with AXI4-Lite register access
// Assumes: 40 MHz aclk, hw_reset_n pin asynchronous to aclk
// Notes: aresetn loads the factory state of the part
module spl_top
    import spl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic hw_reset_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [NUM_BLOCKS-1:0] block_protected,
    output logic array_read_blocked,
    output logic operation_pending_flag,
    output logic guard_lock_bit
);
    import spl_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic is_unprot(input logic pg, input logic vg);
        return pg & vg;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    spl_state_e state_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [NUM_BLOCKS-1:0] persistent_sector_guard;
    logic [NUM_BLOCKS-1:0] volatile_sector_guard;
    logic [PWD_W-1:0] pwd_reg;
    logic [PWD_W-1:0] rdbk_reg;
    logic [ASP_W-1:0] advanced_protection_reg;
    logic [31:0] data_lo_reg;
    logic [31:0] data_hi_reg;
    logic [BLK_W-1:0] sel_reg;
    logic [BLK_W-1:0] op_blk_reg;
    logic lock_reg;
    logic prog_err_reg;
    logic prot_err_reg;
    logic hw_meta_reg;
    logic hw_sync_reg;
    logic aw_have_reg;
    logic w_have_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [NUM_BLOCKS-1:0] prot_vec_reg;
    logic blocked_reg;

    // ------------------------------------------------------------
    // hardware reset pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hw_meta_reg <= 1'b1;
            hw_sync_reg <= 1'b1;
        end
        else
        begin
            hw_meta_reg <= hw_reset_n;
            hw_sync_reg <= hw_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // axi write channel
    // ------------------------------------------------------------
    logic wr_fire;
    logic wr_known;
    assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
    assign wr_known = aw_addr_reg == OFS_CTRL ||
        aw_addr_reg == OFS_DATA_LO || aw_addr_reg == OFS_DATA_HI ||
        aw_addr_reg == OFS_BLK_SEL;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && !aw_have_reg)
            begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && !w_have_reg)
            begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_reg && s_axi_bready)
            begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic cmd_go;
    logic accept;
    logic [3:0] op;
    logic [BLK_W-1:0] op_blk;
    logic op_val;
    logic pwd_mode;
    logic hw_rst;
    logic pwr;
    logic pwd_match;
    logic [PWD_W-1:0] cmd_data;
    assign cmd_go = wr_fire && aw_addr_reg == OFS_CTRL && w_strb_reg[0];
    assign op = w_data_reg[CMD_OP_LSB +: 4];
    assign op_blk = w_data_reg[CMD_BLK_LSB +: BLK_W];
    assign op_val = w_data_reg[CMD_VAL_BIT];
    assign accept = cmd_go && state_reg == ST_IDLE;
    assign pwd_mode = !advanced_protection_reg[ASP_PWD_BIT];
    assign hw_rst = !hw_sync_reg;
    assign pwr = accept && op == OP_POWER_CYCLE;
    assign cmd_data = {data_hi_reg, data_lo_reg};
    assign pwd_match = cmd_data == pwd_reg;

    logic op_prog;
    logic op_erase;
    logic guard_fail;
    logic unlock_try;
    logic unlock_bad;
    assign op_prog = accept && op == OP_PROG_GUARD;
    assign op_erase = accept && op == OP_ERASE_GUARD;
    assign guard_fail = (op_prog || op_erase) && !lock_reg;
    assign unlock_try = accept && op == OP_PWD_UNLOCK && pwd_mode;
    assign unlock_bad = unlock_try && !pwd_match;

    // ------------------------------------------------------------
    // operation sequencer
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
            op_blk_reg <= '0;
        end
        else if (hw_rst || pwr)
        begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if ((op_prog || op_erase) && lock_reg)
                    begin
                        state_reg <= op_prog ? ST_PROG : ST_ERASE;
                        cnt_reg <= op_prog ? CNT_W'(PROG_CYC - 1)
                                           : CNT_W'(ERASE_CYC - 1);
                        op_blk_reg <= op_blk;
                    end
                    else if (unlock_bad)
                    begin
                        state_reg <= ST_WAIT;
                        cnt_reg <= CNT_W'(UNLOCK_CYC - 1);
                    end
                end
                ST_PROG, ST_ERASE, ST_WAIT:
                begin
                    if (cnt_reg == '0)
                    begin
                        state_reg <= ST_IDLE;
                    end
                    else
                    begin
                        cnt_reg <= cnt_reg - CNT_W'(1);
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // persistent guards
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            persistent_sector_guard <= '1;
        end
        // changes only after an unlocked program or erase
        else if (!hw_rst && !pwr && cnt_reg == '0)
        begin
            // single program to 0, group erase to 1
            if (state_reg == ST_PROG)
            begin
                persistent_sector_guard[op_blk_reg] <= 1'b0;
            end
            else if (state_reg == ST_ERASE)
            begin
                persistent_sector_guard <= '1;
            end
        end
    end

    // ------------------------------------------------------------
    // volatile guards
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            volatile_sector_guard <= '1;
        end
        // any reset returns volatile guards to 1
        else if (hw_rst || pwr || (accept && op == OP_SOFT_RESET))
        begin
            volatile_sector_guard <= '1;
        end
        else if (accept && op == OP_WRITE_VOL)
        begin
            volatile_sector_guard[op_blk] <= op_val;
        end
    end

    // ------------------------------------------------------------
    // lock bit
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lock_reg <= 1'b1;
        end
        else if (hw_rst || pwr)
        begin
            lock_reg <= !pwd_mode;
        end
        // clear command clears it; only a pin reset or power cycle in persistent mode, or a password unlock, sets it again
        else if (accept && op == OP_LOCK_CLEAR)
        begin
            lock_reg <= 1'b0;
        end
        else if (unlock_try && pwd_match)
        begin
            lock_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // password store and mode bits
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pwd_reg <= PWD_FACTORY;
            rdbk_reg <= '0;
            advanced_protection_reg <= ASP_FACTORY;
        end
        else
        begin
            // password access ignored in password mode
            if (accept && op == OP_PWD_PROG && !pwd_mode)
            begin
                pwd_reg <= pwd_reg & cmd_data;
            end
            // readback only by the password read
            if (accept && op == OP_PWD_READ && !pwd_mode)
            begin
                rdbk_reg <= pwd_reg;
            end
            if (accept && op == OP_ASP_PROG)
            begin
                advanced_protection_reg <= advanced_protection_reg &
                    {data_lo_reg[ASP_PWD_BIT], data_lo_reg[ASP_PERSIST_BIT],
                     1'b1};
            end
        end
    end

    // ------------------------------------------------------------
    // error flags
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            prog_err_reg <= 1'b0;
            prot_err_reg <= 1'b0;
        end
        else if (guard_fail || unlock_bad)
        begin
            prog_err_reg <= 1'b1;
            prot_err_reg <= 1'b1;
        end
        else if (accept && op == OP_CLR_ERR)
        begin
            prog_err_reg <= 1'b0;
            prot_err_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // data and select registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            data_lo_reg <= '0;
            data_hi_reg <= '0;
            sel_reg <= '0;
        end
        else if (wr_fire)
        begin
            if (aw_addr_reg == OFS_DATA_LO)
            begin
                data_lo_reg <= merge(data_lo_reg, w_data_reg, w_strb_reg);
            end
            if (aw_addr_reg == OFS_DATA_HI)
            begin
                data_hi_reg <= merge(data_hi_reg, w_data_reg, w_strb_reg);
            end
            if (aw_addr_reg == OFS_BLK_SEL && w_strb_reg[0])
            begin
                sel_reg <= w_data_reg[BLK_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // protection map and pins
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            prot_vec_reg <= '0;
            blocked_reg <= 1'b0;
        end
        else
        begin
            // protected unless both guards are 1
            for (int i = 0; i < NUM_BLOCKS; i++)
            begin
                prot_vec_reg[i] <= !is_unprot(persistent_sector_guard[i],
                    volatile_sector_guard[i]);
            end
            // array reads held off while programming
            blocked_reg <= state_reg == ST_PROG && cnt_reg != '0 &&
                !hw_rst && !pwr;
        end
    end

    // ------------------------------------------------------------
    // axi read channel
    // ------------------------------------------------------------
    spl_status_s status;
    always_comb
    begin
        status.read_blocked = blocked_reg;
        status.persist_mode = !pwd_mode;
        status.pwd_mode = pwd_mode;
        status.lock = lock_reg;
        status.prot_err = prot_err_reg;
        status.prog_err = prog_err_reg;
        status.pending = state_reg != ST_IDLE;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end
        else if (s_axi_arvalid && !rvalid_reg)
        begin
            rvalid_reg <= 1'b1;
            rresp_reg <= RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                OFS_CTRL: rdata_reg <= '0;
                OFS_DATA_LO: rdata_reg <= data_lo_reg;
                OFS_DATA_HI: rdata_reg <= data_hi_reg;
                OFS_STATUS: rdata_reg <= 32'(status);
                OFS_BLK_SEL: rdata_reg <= {21'h000000,
                    is_unprot(persistent_sector_guard[sel_reg],
                              volatile_sector_guard[sel_reg]),
                    volatile_sector_guard[sel_reg],
                    persistent_sector_guard[sel_reg], sel_reg};
                OFS_RDBK_LO: rdata_reg <= rdbk_reg[31:0];
                OFS_RDBK_HI: rdata_reg <= rdbk_reg[63:32];
                OFS_ASP: rdata_reg <= 32'(advanced_protection_reg);
                default:
                begin
                    rdata_reg <= '0;
                    rresp_reg <= RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_reg && s_axi_rready)
        begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_awready = !aw_have_reg;
    assign s_axi_wready = !w_have_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign block_protected = prot_vec_reg;
    assign array_read_blocked = blocked_reg;
    assign operation_pending_flag = state_reg != ST_IDLE;
    assign guard_lock_bit = lock_reg;

endmodule

// ===== verif/spl_host.sv
// Purpose: AXI4-Lite host issuing lock block commands
// Assumes: signals change by NBA after rising aclk
// Notes: one write and one read at a time
module spl_host
    import spl_pkg::*;
(
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid,
        s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        forever
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        forever
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic cmd(input logic [31:0] w);
        logic [31:0] s;
        logic [1:0] r;
        wr(OFS_CTRL, w, r);
        do rd(OFS_STATUS, s, r); while (s[0] !== 1'h0);
    endtask
endmodule

// ===== verif/spl_props.sv
// Purpose: port checks for spl_top
// Assumes: aresetn synchronous, active low
// Notes: bound to every spl_top instance
module spl_props
    import spl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic hw_reset_n,
    input wire logic s_axi_arready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic array_read_blocked,
    input wire logic operation_pending_flag,
    input wire logic guard_lock_bit
);
    logic [3:0] hw_hist;
    logic [12:0] pend_cnt;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    always_ff @(posedge aclk)
    begin
        hw_hist <= {hw_hist[2:0], hw_reset_n};
    end
    always_ff @(posedge aclk)
    begin
        pend_cnt <= operation_pending_flag ? pend_cnt + 13'h1 : 13'h0;
    end
    lock_rise_a: assert property (
        $rose(guard_lock_bit) |-> $rose(s_axi_bvalid) || hw_hist != 4'hF)
        else $error("lock bit rose without command or pin");
    lock_fall_a: assert property (
        $fell(guard_lock_bit) |-> $rose(s_axi_bvalid) || hw_hist != 4'hF)
        else $error("lock bit fell without command or pin");
    unlock_fast_a: assert property (
        $rose(guard_lock_bit) && $rose(s_axi_bvalid) |->
        !operation_pending_flag)
        else $error("unlock left pending set");
    pend_bound_a: assert property (pend_cnt <= 13'h12C0)
        else $error("pending longer than 120 us");
    read_block_a: assert property (
        array_read_blocked |-> operation_pending_flag)
        else $error("reads blocked while idle");
    rhold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    bhold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped early");
    ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer open");
endmodule
bind spl_top spl_props spl_props_i (.*);

// ===== verif/testbench.sv
// Purpose: self-checking bench for spl_top
// Assumes: 40 MHz aclk, host model drives the register bus
// Notes: rows give command, status[3:0] and one block's protection
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import spl_pkg::*;
    logic aclk, aresetn, hw_reset_n;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [3:0] s_axi_wstrb;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, array_read_blocked;
    logic operation_pending_flag, guard_lock_bit;
    logic [NUM_BLOCKS-1:0] block_protected;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    int n;
    logic [36:0] rows [14] = '{
        {32'h0503, 4'h8, 1'h1}, // volatile protects
        {32'h10503, 4'h8, 1'h0}, // volatile frees
        {32'h0501, 4'h8, 1'h1}, // program one
        {32'h10503, 4'h8, 1'h1}, // both needed
        {32'h0509, 4'h8, 1'h1}, // kept on reset
        {32'h0502, 4'h8, 1'h0}, // erase all
        {32'h0601, 4'h8, 1'h1}, // program block 6
        {32'h0604, 4'h0, 1'h1}, // clear after setup
        {32'h0602, 4'h6, 1'h1}, // locked erase fails
        {32'h060B, 4'h0, 1'h1}, // flags cleared
        {32'h0609, 4'h0, 1'h1}, // soft reset keeps
        {32'h060A, 4'h8, 1'h1}, // power-up sets
        {32'h0703, 4'h8, 1'h1}, // volatile protects
        {32'h0709, 4'h8, 1'h0}}; // volatile reverts
    spl_top spl_top_i (.*);
    spl_host spl_host_i (.*);
    initial
    begin
        aclk = 1'h0;
        forever #12.5 aclk = ~aclk;
    end
    task automatic check(input string nm, input logic [63:0] seen,
        input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        if (bad_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic setd(input logic [31:0] hi, input logic [31:0] lo);
        spl_host_i.wr(OFS_DATA_LO, lo, rr);
        spl_host_i.wr(OFS_DATA_HI, hi, rr);
    endtask
    task automatic pwd_check(input logic [31:0] hi, input logic [31:0] lo);
        spl_host_i.rd(OFS_RDBK_LO, rv, rr);
        check("pwd lo", rv, lo);
        spl_host_i.rd(OFS_RDBK_HI, rv, rr);
        check("pwd hi", rv, hi);
    endtask
    task automatic hw_pulse();
        hw_reset_n <= 1'h0;
        repeat (4) @(posedge aclk);
        hw_reset_n <= 1'h1;
        repeat (4) @(posedge aclk);
    endtask
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            report_and_stop();
        end
    end
    initial
    begin
        {aresetn, hw_reset_n, s_axi_wstrb} <= 6'h1F;
        {s_axi_awprot, s_axi_arprot} <= 6'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        check("lock", guard_lock_bit, 1'h1);
        check("prot", {63'h0, |block_protected}, 64'h0);
        foreach (rows[i])
        begin
            spl_host_i.cmd(rows[i][36:5]);
            spl_host_i.rd(OFS_STATUS, rv, rr);
            check("status", rv[3:0], rows[i][4:1]);
            check("prot", block_protected[rows[i][20:13]], rows[i][0]);
        end
        {s_axi_wstrb, s_axi_awprot, s_axi_arprot} <= 10'h391;
        spl_host_i.wr(OFS_CTRL, 32'h4, rr);
        s_axi_wstrb <= 4'hF;
        check("lock", guard_lock_bit, 1'h1);
        spl_host_i.cmd(32'h4);
        hw_pulse();
        check("lock", guard_lock_bit, 1'h1);
        spl_host_i.cmd(32'h6);
        pwd_check(32'hFFFFFFFF, 32'hFFFFFFFF);
        setd(32'h12345678, 32'h0F0FFFFF);
        spl_host_i.cmd(32'h5);
        setd(32'hFFFFFFFF, 32'hF0F000FF);
        spl_host_i.cmd(32'h5);
        spl_host_i.cmd(32'h6);
        pwd_check(32'h12345678, 32'h000000FF);
        setd(32'h0, 32'h3);
        spl_host_i.cmd(32'h8);
        setd(32'h0, 32'hFFFFFFFF);
        spl_host_i.cmd(32'h8);
        spl_host_i.rd(OFS_ASP, rv, rr);
        check("mode", rv[2], 1'h0);
        setd(32'h0, 32'h0);
        spl_host_i.cmd(32'h5);
        spl_host_i.cmd(32'h6);
        pwd_check(32'h12345678, 32'h000000FF);
        spl_host_i.cmd(32'hA);
        check("lock", guard_lock_bit, 1'h0);
        setd(32'h12345678, 32'h000000FE);
        spl_host_i.wr(OFS_CTRL, 32'h7, rr);
        n = 0;
        while (operation_pending_flag === 1'h1 && n < 6000)
        begin
            @(posedge aclk);
            n++;
        end
        check("wait", {63'h0, n >= 3200 && n <= 4800}, 64'h1);
        spl_host_i.rd(OFS_STATUS, rv, rr);
        check("status", rv[3:0], 4'h6);
        spl_host_i.cmd(32'hB);
        setd(32'h12345678, 32'h000000FF);
        spl_host_i.wr(OFS_CTRL, 32'h7, rr);
        check("pend", operation_pending_flag, 1'h0);
        check("lock", guard_lock_bit, 1'h1);
        hw_pulse();
        check("lock", guard_lock_bit, 1'h0);
        spl_host_i.rd(8'h20, rv, rr);
        check("resp", rr, RESP_SLVERR);
        spl_host_i.wr(8'h24, 32'h0, rr);
        check("resp", rr, RESP_SLVERR);
        report_and_stop();
    end
endmodule
